// *** rtl/dmb_defines.svh ***
// named constants for the data memory bank select block
// assumes inclusion by bare name from rtl files of this block
`ifndef DMB_DEFINES_SVH
`define DMB_DEFINES_SVH

// address layout: 4-bit bank over 8-bit low part
`define DMB_ADDR_W        12
`define DMB_LOW_W         8
`define DMB_BANK_W        4
`define DMB_LOW_MSB       7

// the three banks that may be selected
`define DMB_BANK_RAM      4'h0
`define DMB_BANK_NVM      4'h4
`define DMB_BANK_PERIPH   4'hF

// fixed-bank split point for direct operands
`define DMB_LOW_SPLIT     8'h80

// region limits
`define DMB_RAM_LO        12'h000
`define DMB_RAM_HI        12'h07F
`define DMB_NVM_LO        12'h400
`define DMB_NVM_HI        12'h41F
`define DMB_PERIPH_LO     12'hF80
`define DMB_PERIPH_HI     12'hFFF

// reset values
`define DMB_RST_FLAG      1'h0
`define DMB_RST_PULSE     1'h0
`define DMB_RST_BANK      4'h0
`define DMB_RST_ADDR      12'h000

// flag save stack
`define DMB_STK_AW        4
`define DMB_STK_DEPTH     16
`define DMB_STK_ONE       4'h1
`define DMB_STK_RST_SP    4'h0

`endif

// *** rtl/dmb_pkg.sv ***
// types shared by the data memory bank select block
// assumes dmb_defines.svh is on the include path
`include "dmb_defines.svh"

package dmb_pkg;

    // how the low address part was supplied
    typedef enum logic [1:0] {
        DMB_MODE_DIRECT = 2'b00,  // operand, fixed rule when flag clear
        DMB_MODE_HL     = 2'b01,  // register indirect through bank
        DMB_MODE_PAIR   = 2'b10,  // pointer_pair_e / pointer_pair_l
        DMB_MODE_STACK  = 2'b11   // stack area, bank zero
    } dmb_mode_t;

    // bank used for one access
    function automatic logic [`DMB_BANK_W-1:0] dmb_bank_for(
        input dmb_mode_t              mode,
        input logic [`DMB_LOW_W-1:0]  low,
        input logic                   flag,
        input logic [`DMB_BANK_W-1:0] sel
    );
        logic [`DMB_BANK_W-1:0] b;
        b = `DMB_BANK_RAM;
        case (mode)
            DMB_MODE_DIRECT: begin
                if (flag)
                    b = sel;
                else if (low < `DMB_LOW_SPLIT)
                    b = `DMB_BANK_RAM;
                else
                    b = `DMB_BANK_PERIPH;
            end
            DMB_MODE_HL:    b = flag ? sel : `DMB_BANK_RAM;
            DMB_MODE_PAIR:  b = `DMB_BANK_RAM;
            DMB_MODE_STACK: b = `DMB_BANK_RAM;
            default:        b = `DMB_BANK_RAM;
        endcase
        return b;
    endfunction

endpackage

// *** rtl/dmb_stack_if.sv ***
// carrier between the bank logic and its flag save stack
// assumes one clock shared by both ends
`timescale 1ns/1ps
`include "dmb_defines.svh"

interface dmb_stack_if;
    logic                   wr_en;
    logic [`DMB_STK_AW-1:0] wr_addr;
    logic                   wr_data;
    logic [`DMB_STK_AW-1:0] rd_addr;
    logic                   rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// *** rtl/dmb_flag_stack.sv ***
// small memory holding saved bank enable flags
// assumes single clock; read data registered, write-first on a collision
`timescale 1ns/1ps
`include "dmb_defines.svh"

module dmb_flag_stack
    import dmb_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // access port
    dmb_stack_if.mem port
);

    logic mem_q [`DMB_STK_DEPTH];
    logic rd_data_reg;

    // storage write
    always_ff @(posedge mclk) begin
        if (port.wr_en)
            mem_q[port.wr_addr] <= port.wr_data;
    end

    // registered read, new data forwarded so the top is never stale
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            rd_data_reg <= `DMB_RST_FLAG;
        else if (port.wr_en && port.wr_addr == port.rd_addr)
            rd_data_reg <= port.wr_data;
        else
            rd_data_reg <= mem_q[port.rd_addr];
    end

    assign port.rd_data = rd_data_reg;

endmodule

// *** rtl/dmb_bank_select.sv ***
// data memory bank addressing: bank enable flag, bank select, address build
// assumes the core decodes instructions into one-cycle strobes on mclk
`timescale 1ns/1ps
`include "dmb_defines.svh"

// Behaviour
// [R1] static RAM occupies addresses 000H to 07FH in bank zero
// [R2] nonvolatile data memory occupies 400H to 41FH in bank four
// [R3] peripheral hardware occupies F80H to FFFH in bank fifteen
// [R4] address is instruction low 8 bits under active bank high 4 bits
// [R5] data space is 12 address bits, up to 4K words of 4 bits
// [R6] bank select accepts only banks zero, four and fifteen
// [R7] flag clear: active bank follows fixed rule, bank select ignored
// [R8] flag set: active bank equals bank select register
// [R9] flag saved on subroutine call and restored on return
// [R10] interrupt entry saves flag, loads vector value; interrupt return restores
// [R11] software saves bank select itself across handlers; hardware keeps none
// [R12] flag changes only by bit set/clear; bank select by select instruction
// [R13] flag clear: direct 00H-7FH is bank zero, 80H-FFH bank fifteen
// [R14] pointer pair accesses always target bank zero
// [R15] reset clears bank select to zero and flag to a defined value
// [R16] a new bank setting applies to the very next instruction's access
module dmb_bank_select
    import dmb_pkg::*;
(
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset,
    // flag and select instructions
    input  wire logic                   bit_set_instr,
    input  wire logic                   bit_clear_instr,
    input  wire logic                   sel_instr,
    input  wire logic [`DMB_BANK_W-1:0] sel_value,
    // program flow events
    input  wire logic                   call_strobe,
    input  wire logic                   return_strobe,
    input  wire logic                   int_entry,
    input  wire logic                   int_vector_flag,
    input  wire logic                   interrupt_return_instr,
    // address request
    input  wire logic                   access_valid,
    input  wire dmb_mode_t              access_mode,
    input  wire logic [`DMB_LOW_W-1:0]  access_low,
    // formed address and region selects
    output logic                        addr_valid,
    output logic [`DMB_ADDR_W-1:0]      data_addr,
    output logic [`DMB_BANK_W-1:0]      active_bank,
    output logic                        ram_sel,
    output logic                        nvm_sel,
    output logic                        periph_sel,
    // bank state
    output logic                        bank_enable_flag,
    output logic [`DMB_BANK_W-1:0]      bank_select_reg,
    output logic                        sel_reject
);

    // inclusive range test on a data address
    function automatic logic in_range(
        input logic [`DMB_ADDR_W-1:0] a,
        input logic [`DMB_ADDR_W-1:0] lo,
        input logic [`DMB_ADDR_W-1:0] hi
    );
        return (a >= lo) && (a <= hi);
    endfunction

    // bank numbers that the select instruction may load
    function automatic logic bank_ok(input logic [`DMB_BANK_W-1:0] b);
        return (b == `DMB_BANK_RAM) || (b == `DMB_BANK_NVM) || (b == `DMB_BANK_PERIPH);
    endfunction

    dmb_stack_if stk ();

    logic                   flag_reg;
    logic [`DMB_BANK_W-1:0] sel_reg;
    logic [`DMB_STK_AW-1:0] sp_reg;
    logic [`DMB_STK_AW-1:0] sp_next;
    logic                   push;
    logic                   pop;
    logic [`DMB_BANK_W-1:0] bank_now;
    logic [`DMB_ADDR_W-1:0] addr_now;

    // save stack of flags
    dmb_flag_stack u_stack (
        .mclk  (mclk),
        .reset (reset),
        .port  (stk)
    );

    // push on call or interrupt entry, pop on either return unless a push comes in the same cycle
    assign push = call_strobe | int_entry;                           // see [R9] see [R10]
    assign pop  = (return_strobe | interrupt_return_instr) & ~push;  // see [R9] see [R10]

    always_comb begin
        sp_next = sp_reg;
        if (push)
            sp_next = sp_reg + `DMB_STK_ONE;
        else if (pop)
            sp_next = sp_reg - `DMB_STK_ONE;
    end

    // stack port: write at free slot, read the top that follows this edge
    assign stk.wr_en   = push;
    assign stk.wr_addr = sp_reg;
    assign stk.wr_data = flag_reg;
    assign stk.rd_addr = sp_next - `DMB_STK_ONE;

    // stack pointer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            sp_reg <= `DMB_STK_RST_SP;
        else
            sp_reg <= sp_next;
    end

    // bank enable flag: entry load, then restore, then set/clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            flag_reg <= `DMB_RST_FLAG;                     // see [R15]
        else if (int_entry)
            flag_reg <= int_vector_flag;                   // see [R10]
        else if (pop)
            flag_reg <= stk.rd_data;                       // see [R9] see [R10]
        else if (bit_set_instr)
            flag_reg <= 1'h1;                              // see [R12]
        else if (bit_clear_instr)
            flag_reg <= 1'h0;                              // see [R12]
    end

    // bank select register, only the three legal banks load
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            sel_reg <= `DMB_RST_BANK;                      // see [R15]
        else if (sel_instr && bank_ok(sel_value))
            sel_reg <= sel_value;                          // see [R6] see [R12]
    end

    // one-cycle flag for an illegal select value
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            sel_reject <= `DMB_RST_PULSE;
        else
            sel_reject <= sel_instr & ~bank_ok(sel_value); // see [R6]
    end

    // bank from the current registers, so a change shows on the next access
    assign bank_now = dmb_bank_for(access_mode, access_low, flag_reg, sel_reg); // see [R7] see [R8] see [R13] see [R14] see [R16]
    assign addr_now = {bank_now, access_low};                                     // see [R4] see [R5]

    // registered address output
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            addr_valid  <= `DMB_RST_PULSE;
            data_addr   <= `DMB_RST_ADDR;
            active_bank <= `DMB_RST_BANK;
        end else begin
            addr_valid <= access_valid;
            if (access_valid) begin
                data_addr   <= addr_now;                   // see [R4]
                active_bank <= bank_now;
            end
        end
    end

    // region decode, registered beside the address
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ram_sel    <= `DMB_RST_PULSE;
            nvm_sel    <= `DMB_RST_PULSE;
            periph_sel <= `DMB_RST_PULSE;
        end else begin
            ram_sel    <= access_valid & in_range(addr_now, `DMB_RAM_LO, `DMB_RAM_HI);          // see [R1]
            nvm_sel    <= access_valid & in_range(addr_now, `DMB_NVM_LO, `DMB_NVM_HI);          // see [R2]
            periph_sel <= access_valid & in_range(addr_now, `DMB_PERIPH_LO, `DMB_PERIPH_HI);    // see [R3]
        end
    end

    // state outputs
    assign bank_enable_flag = flag_reg;
    assign bank_select_reg  = sel_reg;

    // checks of the addressing behaviour
    a_sel_legal: assert property (@(posedge mclk) disable iff (reset) // see [R6]
        bank_ok(sel_reg))
        else $error("bank select holds an illegal bank");

    a_fixed_low: assert property (@(posedge mclk) disable iff (reset) // see [R13]
        access_valid && access_mode == DMB_MODE_DIRECT && !flag_reg && access_low < `DMB_LOW_SPLIT
        |=> data_addr[`DMB_ADDR_W-1:`DMB_LOW_W] == `DMB_BANK_RAM)
        else $error("low direct operand with flag clear not in bank zero");

    a_fixed_high: assert property (@(posedge mclk) disable iff (reset) // see [R7]
        access_valid && access_mode == DMB_MODE_DIRECT && !flag_reg && access_low >= `DMB_LOW_SPLIT
        |=> data_addr[`DMB_ADDR_W-1:`DMB_LOW_W] == `DMB_BANK_PERIPH)
        else $error("high direct operand with flag clear not in bank fifteen");

    a_flag_bank: assert property (@(posedge mclk) disable iff (reset) // see [R8]
        access_valid && access_mode == DMB_MODE_DIRECT && flag_reg
        |=> active_bank == $past(sel_reg))
        else $error("flag set but bank differs from bank select");

    a_pair_bank: assert property (@(posedge mclk) disable iff (reset) // see [R14]
        access_valid && access_mode == DMB_MODE_PAIR
        |=> addr_valid && data_addr[`DMB_ADDR_W-1:`DMB_LOW_W] == `DMB_BANK_RAM)
        else $error("pointer pair access left bank zero");

    a_low_part: assert property (@(posedge mclk) disable iff (reset) // see [R4]
        access_valid |=> data_addr[`DMB_LOW_MSB:0] == $past(access_low))
        else $error("low address part not passed through");

    a_ram_region: assert property (@(posedge mclk) disable iff (reset) // see [R1]
        addr_valid |-> ram_sel == (data_addr <= `DMB_RAM_HI))
        else $error("ram select disagrees with address");

    a_nvm_region: assert property (@(posedge mclk) disable iff (reset) // see [R2]
        addr_valid |-> nvm_sel == (data_addr >= `DMB_NVM_LO && data_addr <= `DMB_NVM_HI))
        else $error("nonvolatile select disagrees with address");

    a_periph_region: assert property (@(posedge mclk) disable iff (reset) // see [R3]
        addr_valid |-> periph_sel == (data_addr >= `DMB_PERIPH_LO))
        else $error("peripheral select disagrees with address");

    a_call_restore: assert property (@(posedge mclk) disable iff (reset) // see [R9]
        (call_strobe && !int_entry) ##1 bit_set_instr[*1] ##1 (return_strobe && !push)
        |=> flag_reg == $past(flag_reg, 3))
        else $error("flag not restored after subroutine return");

    a_int_load: assert property (@(posedge mclk) disable iff (reset) // see [R10]
        int_entry |=> flag_reg == $past(int_vector_flag))
        else $error("flag not loaded from vector on interrupt entry");

    a_int_restore: assert property (@(posedge mclk) disable iff (reset) // see [R10]
        (int_entry && !flag_reg) ##1 (interrupt_return_instr && !push) |=> !flag_reg)
        else $error("flag not restored after interrupt return");

    a_flag_only_instr: assert property (@(posedge mclk) disable iff (reset) // see [R12]
        !int_entry && !pop && !bit_set_instr && !bit_clear_instr |=> $stable(flag_reg))
        else $error("flag changed without an instruction");

    a_reset_state: assert property (@(posedge mclk) disable iff (reset) // see [R15]
        $fell(reset) |-> sel_reg == `DMB_BANK_RAM && flag_reg == `DMB_RST_FLAG)
        else $error("bank state not cleared by reset");

    a_next_instr: assert property (@(posedge mclk) disable iff (reset) // see [R16]
        sel_instr && bank_ok(sel_value) && !int_entry ##1 bit_set_instr && !sel_instr && !int_entry && !pop
        ##1 access_valid && access_mode == DMB_MODE_HL
        |=> active_bank == $past(sel_value, 3))
        else $error("new bank not used by following access");

    // checks of register updates, stack pointer and address hold
    a_sel_hold: assert property (@(posedge mclk) disable iff (reset) // see [R12]
        !sel_instr |=> $stable(sel_reg))
        else $error("bank select changed without a select instruction");

    a_sel_load: assert property (@(posedge mclk) disable iff (reset) // see [R6]
        sel_instr && bank_ok(sel_value) |=> sel_reg == $past(sel_value))
        else $error("legal bank select value not loaded");

    a_sel_refuse: assert property (@(posedge mclk) disable iff (reset) // see [R6]
        sel_instr && !bank_ok(sel_value) |=> sel_reject && $stable(sel_reg))
        else $error("illegal bank select value not refused");

    a_reject_quiet: assert property (@(posedge mclk) disable iff (reset) // see [R6]
        !sel_instr |=> !sel_reject)
        else $error("refusal pulse without a select instruction");

    a_flag_set: assert property (@(posedge mclk) disable iff (reset) // see [R12]
        bit_set_instr && !int_entry && !pop |=> flag_reg)
        else $error("flag not set by bit set");

    a_flag_clear: assert property (@(posedge mclk) disable iff (reset) // see [R12]
        bit_clear_instr && !bit_set_instr && !int_entry && !pop |=> !flag_reg)
        else $error("flag not cleared by bit clear");

    a_hl_bank: assert property (@(posedge mclk) disable iff (reset) // see [R8]
        access_valid && access_mode == DMB_MODE_HL
        |=> active_bank == ($past(flag_reg) ? $past(sel_reg) : `DMB_BANK_RAM))
        else $error("register indirect access in wrong bank");

    a_stack_bank: assert property (@(posedge mclk) disable iff (reset) // see [R4]
        access_valid && access_mode == DMB_MODE_STACK |=> active_bank == `DMB_BANK_RAM)
        else $error("stack access left bank zero");

    a_bank_field: assert property (@(posedge mclk) disable iff (reset) // see [R4]
        addr_valid |-> data_addr[`DMB_ADDR_W-1:`DMB_LOW_W] == active_bank)
        else $error("address high part differs from active bank");

    a_addr_hold: assert property (@(posedge mclk) disable iff (reset) // see [R4]
        !access_valid |=> !addr_valid && $stable(data_addr) && $stable(active_bank))
        else $error("address changed without a request");

    a_region_idle: assert property (@(posedge mclk) disable iff (reset) // see [R3]
        !addr_valid |-> !ram_sel && !nvm_sel && !periph_sel)
        else $error("region select without an address");

    a_region_one: assert property (@(posedge mclk) disable iff (reset) // see [R5]
        $onehot0({ram_sel, nvm_sel, periph_sel}))
        else $error("more than one region selected");

    a_push_sp: assert property (@(posedge mclk) disable iff (reset) // see [R9]
        push |=> sp_reg == $past(sp_reg) + `DMB_STK_ONE)
        else $error("stack pointer not advanced on save");

    a_pop_sp: assert property (@(posedge mclk) disable iff (reset) // see [R9]
        pop |=> sp_reg == $past(sp_reg) - `DMB_STK_ONE)
        else $error("stack pointer not stepped back on restore");

endmodule

// *** testbench/dmb_bank_select_tb.sv ***
// self-checking bench for the data memory bank select block
// assumes the rtl package, interface and defines header are compiled first
`timescale 1ns/1ps
`include "dmb_defines.svh"

module dmb_bank_select_tb
    import dmb_pkg::*;
();
    // one table row: bank state, request, expected bank
    typedef struct packed {
        logic       flag;
        logic [3:0] sel;
        dmb_mode_t  mode;
        logic [7:0] low;
        logic [3:0] bank;
    } dmb_row_t;

    logic        mclk;
    logic        reset;
    logic        bit_set_instr;
    logic        bit_clear_instr;
    logic        sel_instr;
    logic [3:0]  sel_value;
    logic        call_strobe;
    logic        return_strobe;
    logic        int_entry;
    logic        int_vector_flag;
    logic        interrupt_return_instr;
    logic        access_valid;
    dmb_mode_t   access_mode;
    logic [7:0]  access_low;
    logic        addr_valid;
    logic [11:0] data_addr;
    logic [3:0]  active_bank;
    logic        ram_sel;
    logic        nvm_sel;
    logic        periph_sel;
    logic        bank_enable_flag;
    logic [3:0]  bank_select_reg;
    logic        sel_reject;
    int          fail_count;
    int          samples_checked;
    logic [3:0]  exp_sel;

    // ordinary cases: boundaries of the fixed rule, bank select use, pointer and stack modes
    dmb_row_t rows [11] = '{
        '{1'h0, 4'h0, DMB_MODE_DIRECT, 8'h7F, 4'h0},
        '{1'h0, 4'h0, DMB_MODE_DIRECT, 8'h80, 4'hF},
        '{1'h0, 4'h4, DMB_MODE_DIRECT, 8'hFF, 4'hF},
        '{1'h1, 4'h4, DMB_MODE_DIRECT, 8'h10, 4'h4},
        '{1'h1, 4'h4, DMB_MODE_DIRECT, 8'h20, 4'h4},
        '{1'h1, 4'hF, DMB_MODE_DIRECT, 8'h05, 4'hF},
        '{1'h1, 4'h4, DMB_MODE_HL,     8'h1F, 4'h4},
        '{1'h0, 4'h4, DMB_MODE_HL,     8'h80, 4'h0},
        '{1'h1, 4'hF, DMB_MODE_PAIR,   8'h90, 4'h0},
        '{1'h0, 4'hF, DMB_MODE_PAIR,   8'h10, 4'h0},
        '{1'h1, 4'h4, DMB_MODE_STACK,  8'h33, 4'h0}
    };

    dmb_bank_select u_dmb_bank_select (
        .mclk                   (mclk),
        .reset                  (reset),
        .bit_set_instr          (bit_set_instr),
        .bit_clear_instr        (bit_clear_instr),
        .sel_instr              (sel_instr),
        .sel_value              (sel_value),
        .call_strobe            (call_strobe),
        .return_strobe          (return_strobe),
        .int_entry              (int_entry),
        .int_vector_flag        (int_vector_flag),
        .interrupt_return_instr (interrupt_return_instr),
        .access_valid           (access_valid),
        .access_mode            (access_mode),
        .access_low             (access_low),
        .addr_valid             (addr_valid),
        .data_addr              (data_addr),
        .active_bank            (active_bank),
        .ram_sel                (ram_sel),
        .nvm_sel                (nvm_sel),
        .periph_sel             (periph_sel),
        .bank_enable_flag       (bank_enable_flag),
        .bank_select_reg        (bank_select_reg),
        .sel_reject             (sel_reject)
    );

    // 25 MHz clock
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end

    // inputs change 1 ns after the rising edge
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask

    task automatic cmp1(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s is %b, expected %b", $time, what, got, exp);
        end
    endtask

    task automatic cmp4(input logic [3:0] got, input logic [3:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s is %h, expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp12(input logic [11:0] got, input logic [11:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s is %h, expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one-cycle flag instruction
    task automatic set_flag(input logic v);
        bit_set_instr = v;
        bit_clear_instr = ~v;
        tick;
        bit_set_instr = 1'h0;
        bit_clear_instr = 1'h0;
        cmp1(bank_enable_flag, v, "flag after set or clear");
    endtask

    // one-cycle bank select instruction
    task automatic select(input logic [3:0] v);
        sel_instr = 1'h1;
        sel_value = v;
        tick;
        sel_instr = 1'h0;
    endtask

    // one-cycle program flow pulses
    task automatic flow(input logic c, input logic r, input logic i);
        call_strobe = c;
        return_strobe = r;
        interrupt_return_instr = i;
        tick;
        call_strobe = 1'h0;
        return_strobe = 1'h0;
        interrupt_return_instr = 1'h0;
    endtask

    // one access, answer checked in the cycle after it stands
    task automatic access(input dmb_mode_t m, input logic [7:0] lo, input logic [3:0] b);
        logic [11:0] a;
        a = {b, lo};
        access_valid = 1'h1;
        access_mode = m;
        access_low = lo;
        tick;
        access_valid = 1'h0;
        cmp1(addr_valid, 1'h1, "addr_valid");
        cmp12(data_addr, a, "data_addr");
        cmp4(active_bank, b, "active_bank");
        cmp1(ram_sel, a <= 12'h07F, "ram_sel");
        cmp1(nvm_sel, a >= 12'h400 && a <= 12'h41F, "nvm_sel");
        cmp1(periph_sel, a >= 12'hF80, "periph_sel");
    endtask

    // hang guard
    initial begin
        #1000000;
        fail_count++;
        $display("wrong value at %0t: run did not complete in time", $time);
        tally_and_finish;
    end

    // main sequence
    initial begin
        {bit_set_instr, bit_clear_instr, sel_instr, call_strobe, return_strobe} = 5'h00;
        {int_entry, int_vector_flag, interrupt_return_instr, access_valid} = 4'h0;
        sel_value = 4'h0;
        access_mode = DMB_MODE_DIRECT;
        access_low = 8'h00;
        fail_count = 0;
        samples_checked = 0;
        reset = 1'h1;
        repeat (4) @(posedge mclk);
        #1;
        reset = 1'h0;
        cmp1(bank_enable_flag, 1'h0, "flag after reset");
        cmp4(bank_select_reg, 4'h0, "select after reset");
        tick;
        // table rows: bank state changed just before the access
        foreach (rows[i]) begin
            select(rows[i].sel);
            set_flag(rows[i].flag);
            access(rows[i].mode, rows[i].low, rows[i].bank);
        end
        tick;
        cmp1(addr_valid, 1'h0, "addr_valid one cycle only");
        // back-to-back direct accesses across the split point
        set_flag(1'h0);
        access_valid = 1'h1;
        access_mode = DMB_MODE_DIRECT;
        access_low = 8'h10;
        tick;
        access_low = 8'h90;
        cmp12(data_addr, 12'h010, "first of pair");
        tick;
        access_valid = 1'h0;
        cmp12(data_addr, 12'hF90, "second of pair");
        cmp1(periph_sel, 1'h1, "second of pair in peripheral area");
        // every select value: only 0, 4 and 15 taken; idle cycle between selects
        exp_sel = 4'h4;
        for (int v = 0; v < 16; v++) begin
            select(v[3:0]);
            if (v == 0 || v == 4 || v == 15)
                exp_sel = v[3:0];
            cmp1(sel_reject, !(v == 0 || v == 4 || v == 15), "sel_reject");
            cmp4(bank_select_reg, exp_sel, "bank select");
            tick;
        end
        // nested calls restore the flag, bank select is left alone
        select(4'h4);
        set_flag(1'h1);
        flow(1'h1, 1'h0, 1'h0);
        set_flag(1'h0);
        select(4'hF);
        flow(1'h1, 1'h0, 1'h0);
        set_flag(1'h1);
        flow(1'h0, 1'h1, 1'h0);
        cmp1(bank_enable_flag, 1'h0, "flag after inner return");
        tick;
        flow(1'h0, 1'h1, 1'h0);
        cmp1(bank_enable_flag, 1'h1, "flag after outer return");
        cmp4(bank_select_reg, 4'hF, "select kept after return");
        // interrupt entry loads vector value, return restores
        for (int v = 0; v < 2; v++) begin
            set_flag(v == 0);
            int_entry = 1'h1;
            int_vector_flag = v[0];
            tick;
            int_entry = 1'h0;
            cmp1(bank_enable_flag, v[0], "flag from vector");
            set_flag(v == 0);
            tick;
            set_flag(v[0]);
            flow(1'h0, 1'h0, 1'h1);
            cmp1(bank_enable_flag, v == 0, "flag after interrupt return");
        end
        // interrupt return straight after entry brings the saved flag back
        set_flag(1'h0);
        int_entry = 1'h1;
        int_vector_flag = 1'h1;
        tick;
        int_entry = 1'h0;
        cmp1(bank_enable_flag, 1'h1, "flag from vector before quick return");
        flow(1'h0, 1'h0, 1'h1);
        cmp1(bank_enable_flag, 1'h0, "flag after quick return");
        // second reset in mid-run acts at once
        select(4'h4);
        set_flag(1'h1);
        reset = 1'h1;
        #2;
        cmp1(bank_enable_flag, 1'h0, "flag in reset");
        cmp4(bank_select_reg, 4'h0, "select in reset");
        tick;
        reset = 1'h0;
        tick;
        access(DMB_MODE_DIRECT, 8'h90, 4'hF);
        tally_and_finish;
    end
endmodule
